// ===== hdl/sram_pin_ctrl.sv
// Device-side control, storage and data pin logic of a pipelined burst SRAM.
`timescale 1ns/100ps
`include "sram_pin_consts.svh"

// Operation
// - Capture full address, burst bits included, on each load edge.
// - Lane selects active low, need write strobe.
// - Each lane writes its byte plus parity.
// - Write strobe sampled only when clock gate low.
// - Advance high steps the burst counter.
// - Advance low loads a fresh external address.
// - Edges with clock gate high are ignored, except that the write buffer keeps draining into the array.
// - Selected only for low, high, low selects.
// - Output enable low lets data pins drive.
// - Drivers off for the beat after write data is taken; a read right before a write drives in its data phase.
// - Drivers off for each deselected beat only, no dead beat after.
// - Gated clock freezes burst, pipeline and output state, does not deselect.
// - Read data registered, from earlier captured address.
// - Strap picks interleaved or linear burst order.
module sram_pin_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic [`ADDR_W-1:`BURST_W] addr_upper,
    input wire logic burst_second_bit,
    input wire logic burst_low_bit,
    input wire logic [`LANES-1:0] byte_lane_write_n,
    input wire logic write_n,
    input wire logic advance_or_load,
    input wire logic clock_gate_n,
    input wire logic select_low_first,
    input wire logic select_high,
    input wire logic select_low_second,
    input wire logic output_enable_n,
    input wire logic burst_order_mode,
    input wire logic [`LANES*`BYTE_W-1:0] dq_in,
    input wire logic [`LANES-1:0] parity_lane_in,
    output logic [`LANES*`BYTE_W-1:0] dq_out,
    output logic [`LANES-1:0] parity_lane_out,
    output logic dq_oe,
    output logic write_buffer_ready
);
    logic enabled;
    logic selected;
    logic mode_r;
    logic mode_seen_r;
    sram_pin_pkg::access_e kind_r;
    logic [`ADDR_W-1:0] base_r;
    logic [`BURST_W-1:0] cnt_r;
    sram_pin_pkg::beat_s beat_nxt;
    sram_pin_pkg::beat_s stage1_r;
    sram_pin_pkg::beat_s stage2_r;
    sram_pin_pkg::wr_s push_data;
    sram_pin_pkg::wr_s drain_data;
    logic push_valid;
    logic push_ready;
    logic drain_valid;
    logic drain_ready;
    logic mem_read;
    logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];
    logic [`DATA_W-1:0] rdata_r;
    logic drive_r;

    // Burst order: interleaved flips the low bits, linear counts them modulo four.
    function automatic logic [`BURST_W-1:0] burst_low(input logic [`BURST_W-1:0] start,
                                                       input logic [`BURST_W-1:0] cnt,
                                                       input logic interleave);
        burst_low = interleave ? (start ^ cnt) : `BURST_W'(start + cnt);
    endfunction : burst_low

    // Parity bit of lane l sits at bit l*9+8, its byte just below it.
    function automatic logic [`DATA_W-1:0] pack_lanes(input logic [`LANES*`BYTE_W-1:0] d,
                                                      input logic [`LANES-1:0] p);
        logic [`DATA_W-1:0] r;
        r = '0;
        for (int l = 0; l < `LANES; l++) begin
            r[l*`LANE_W +: `LANE_W] = {p[l], d[l*`BYTE_W +: `BYTE_W]};
        end
        pack_lanes = r;
    endfunction : pack_lanes

    assign enabled = !clock_gate_n;
    assign selected = !select_low_first && select_high && !select_low_second;

    // The strap is caught once after reset; it must stay static in use.
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_r <= `MODE_INTERLEAVED;
            mode_seen_r <= 1'b0;
        end else if (!mode_seen_r) begin
            mode_r <= burst_order_mode;
            mode_seen_r <= 1'b1;
        end
    end

    // Beat that the current edge would capture.
    always_comb begin
        beat_nxt.lanes_n = byte_lane_write_n;
        if (!advance_or_load) begin
            beat_nxt.addr = {addr_upper, burst_second_bit, burst_low_bit};
            if (!selected) begin
                beat_nxt.kind = sram_pin_pkg::ACC_DESEL;
            end else if (!write_n) begin
                beat_nxt.kind = sram_pin_pkg::ACC_WRITE;
            end else begin
                beat_nxt.kind = sram_pin_pkg::ACC_READ;
            end
        end else begin
            beat_nxt.kind = kind_r;
            beat_nxt.addr = {base_r[`ADDR_W-1:`BURST_W],
                             burst_low(base_r[`BURST_W-1:0], `BURST_W'(cnt_r + 1'b1), mode_r)};
        end
    end

    // Burst state; a gated edge leaves everything as it was.
    always_ff @(posedge clk) begin
        if (srst) begin
            kind_r <= sram_pin_pkg::ACC_DESEL;
            base_r <= '0;
            cnt_r <= '0;
        end else if (enabled) begin
            if (!advance_or_load) begin
                kind_r <= beat_nxt.kind;
                base_r <= beat_nxt.addr;
                cnt_r <= '0;
            end else if (kind_r != sram_pin_pkg::ACC_DESEL) begin
                cnt_r <= `BURST_W'(cnt_r + 1'b1);
            end
        end
    end

    // Two-stage command pipeline shared by reads and writes.
    always_ff @(posedge clk) begin
        if (srst) begin
            stage1_r <= '{kind: sram_pin_pkg::ACC_DESEL, addr: '0, lanes_n: '1};
            stage2_r <= '{kind: sram_pin_pkg::ACC_DESEL, addr: '0, lanes_n: '1};
        end else if (enabled) begin
            stage1_r <= beat_nxt;
            stage2_r <= stage1_r;
        end
    end

    // Write data is taken at the second enabled edge after the command.
    assign push_valid = enabled && (stage2_r.kind == sram_pin_pkg::ACC_WRITE);
    assign push_data = '{addr: stage2_r.addr, lanes_n: stage2_r.lanes_n,
                         data: pack_lanes(dq_in, parity_lane_in)};

    // A read owns the single array port, so the write buffer stalls behind it.
    // The price is a short hazard: a read that reaches the array before an
    // earlier write has drained returns the old word, so callers leave two
    // idle beats before reading back a location that they have just written.
    assign mem_read = enabled && (stage1_r.kind == sram_pin_pkg::ACC_READ);
    assign drain_ready = !mem_read;

    sram_wr_fifo #(
        .WIDTH($bits(sram_pin_pkg::wr_s)),
        .DEPTH(`FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .srst(srst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    // Each lane updates its byte and parity bit on its own.
    always_ff @(posedge clk) begin
        if (drain_valid && drain_ready) begin
            for (int l = 0; l < `LANES; l++) begin
                if (!drain_data.lanes_n[l]) begin
                    mem[drain_data.addr][l*`LANE_W +: `LANE_W] <=
                        drain_data.data[l*`LANE_W +: `LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= '0;
        end else if (mem_read) begin
            rdata_r <= mem[stage1_r.addr];
        end
    end

    // Output register: drives only for a read beat, off in the beat after write data is taken and
    // for a deselected beat; a read right before a write drives in its data phase, and a read right after deselect drives as usual.
    always_ff @(posedge clk) begin
        if (srst) begin
            drive_r <= 1'b0;
            dq_out <= '0;
            parity_lane_out <= '0;
        end else if (enabled) begin
            drive_r <= (stage2_r.kind == sram_pin_pkg::ACC_READ);
            if (stage2_r.kind == sram_pin_pkg::ACC_READ) begin
                for (int l = 0; l < `LANES; l++) begin
                    dq_out[l*`BYTE_W +: `BYTE_W] <= rdata_r[l*`LANE_W +: `BYTE_W];
                    parity_lane_out[l] <= rdata_r[l*`LANE_W + `BYTE_W];
                end
            end
        end
    end

    // Output enable is asynchronous, so it gates the registered drive directly.
    assign dq_oe = drive_r && !output_enable_n;

    // Ready is registered, so it shows a full buffer one cycle late. The buffer
    // drains on every beat without a read, so it never holds more than two writes.
    always_ff @(posedge clk) begin
        if (srst) begin
            write_buffer_ready <= 1'b1;
        end else begin
            write_buffer_ready <= push_ready;
        end
    end
endmodule : sram_pin_ctrl

// ===== hdl/sram_pin_consts.svh
// Constants for the pipelined SRAM pin control block.
`ifndef SRAM_PIN_CONSTS_SVH
`define SRAM_PIN_CONSTS_SVH
`define ADDR_W 19
`define LANES 4
`define BYTE_W 8
`define LANE_W 9
`define DATA_W 36
`define BURST_W 2
`define FIFO_DEPTH 16
`define WR_DATA_LAT 2
`define MODE_INTERLEAVED 1'b1
`endif

// ===== hdl/sram_pin_pkg.sv
// Types shared by the SRAM pin control block.
`include "sram_pin_consts.svh"
package sram_pin_pkg;
    typedef enum logic [1:0] {ACC_DESEL, ACC_READ, ACC_WRITE} access_e;

    typedef struct packed {
        access_e kind;
        logic [`ADDR_W-1:0] addr;
        logic [`LANES-1:0] lanes_n;
    } beat_s;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`LANES-1:0] lanes_n;
        logic [`DATA_W-1:0] data;
    } wr_s;
endpackage : sram_pin_pkg

// ===== hdl/sram_wr_fifo.sv
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module sram_wr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0] wptr_r;
    logic [PW-1:0] rptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != (PW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem[rptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wptr_r <= '0;
            rptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= (wptr_r == PW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= (rptr_r == PW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : sram_wr_fifo

// ===== verification/sram_host_model.sv
// Controller-side model that presents write data on the data lines.
`timescale 1ns/100ps
`include "sram_pin_consts.svh"
module sram_host_model (
    input wire logic clk,
    input wire logic clock_gate_n,
    input wire logic write_n,
    input wire logic [`DATA_W-1:0] wdata,
    output logic [`LANES*`BYTE_W-1:0] dq_in,
    output logic [`LANES-1:0] parity_lane_in
);
    logic stage_r = 1'b0;
    logic [`DATA_W-1:0] stage_d_r = '0;
    logic [`DATA_W-1:0] bus_r = '0;
    // Outside write data beats nobody holds the lines, so the value flips every enabled edge.
    always @(posedge clk) begin
        if (!clock_gate_n) begin
            stage_r <= !write_n;
            stage_d_r <= wdata;
            bus_r <= stage_r ? stage_d_r : ~bus_r;
        end
    end
    assign {parity_lane_in, dq_in} = bus_r;
endmodule : sram_host_model

// ===== verification/sram_pin_props.sv
// Concurrent checks on the pins of the SRAM pin control block.
`timescale 1ns/100ps
`include "sram_pin_consts.svh"
module sram_pin_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic write_n,
    input wire logic advance_or_load,
    input wire logic clock_gate_n,
    input wire logic select_low_first,
    input wire logic select_high,
    input wire logic select_low_second,
    input wire logic output_enable_n,
    input wire logic [`LANES*`BYTE_W-1:0] dq_out,
    input wire logic [`LANES-1:0] parity_lane_out,
    input wire logic dq_oe,
    input wire logic write_buffer_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic sel;
    logic ld;
    assign sel = !select_low_first && select_high && !select_low_second;
    assign ld = !clock_gate_n && !advance_or_load;
    sequence s_two;
        !clock_gate_n ##1 !clock_gate_n;
    endsequence
    property p_reset;
        $fell(srst) |-> !dq_oe && dq_out == '0 && write_buffer_ready;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_oe_mask;
        output_enable_n |-> !dq_oe;
    endproperty
    a_oe_mask: assert property (p_oe_mask) else $error("drive with oe high");
    property p_gate_hold;
        clock_gate_n |=> $stable(dq_out) && $stable(parity_lane_out);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("data moved on gated edge");
    property p_desel_off;
        ld && !sel ##1 s_two |=> !dq_oe;
    endproperty
    a_desel_off: assert property (p_desel_off) else $error("drive while deselected");
    property p_write_off;
        ld && sel && !write_n ##1 s_two |=> !dq_oe;
    endproperty
    a_write_off: assert property (p_write_off) else $error("drive in write data");
    property p_read_on;
        ld && sel && write_n ##1 s_two |=> dq_oe == !output_enable_n;
    endproperty
    a_read_on: assert property (p_read_on) else $error("read drive wrong");
    property p_adv_write;
        ld && sel && !write_n ##1 (!clock_gate_n && advance_or_load) ##1 s_two |=> !dq_oe;
    endproperty
    a_adv_write: assert property (p_adv_write) else $error("drive in burst write");
    property p_oe_follow;
        clock_gate_n ##1 $stable(output_enable_n) |-> $stable(dq_oe);
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("drive moved on gated edge");
    c_read: cover property (ld && sel && write_n);
    c_write: cover property (ld && sel && !write_n);
    c_gate: cover property (clock_gate_n ##1 clock_gate_n);
endmodule : sram_pin_props
bind sram_pin_ctrl sram_pin_props props_u (.clk, .srst, .write_n, .advance_or_load,
    .clock_gate_n, .select_low_first, .select_high, .select_low_second, .output_enable_n,
    .dq_out, .parity_lane_out, .dq_oe, .write_buffer_ready);

// ===== verification/pipelined_sram_pin_control_bench.sv
// Self-checking bench for the SRAM pin control block.
`timescale 1ns/100ps
`include "sram_pin_consts.svh"
module pipelined_sram_pin_control_bench;
    typedef struct packed {
        logic [`ADDR_W-1:0] ad;
        logic [`LANES-1:0] l;
        logic [`DATA_W-1:0] exp;
    } row_s;
    row_s rows [6] = '{'{19'h00000, 4'h0, 36'hF_FFFF_FFFF}, '{19'h7FFFF, 4'hF, 36'h0},
        '{19'h12345, 4'hA, 36'h5_00FF_00FF}, '{19'h00003, 4'h5, 36'hA_FF00_FF00},
        '{19'h40001, 4'hE, 36'h1_0000_00FF}, '{19'h2AAAA, 4'h7, 36'h8_FF00_0000}};
    logic clk = 0, srst = 1, burst_second_bit = 0, burst_low_bit = 0, write_n = 1;
    logic advance_or_load = 0, clock_gate_n = 0, select_low_first = 0, select_high = 0;
    logic select_low_second = 0, output_enable_n = 0, burst_order_mode = 1;
    logic [`ADDR_W-1:`BURST_W] addr_upper = '0;
    logic [`LANES-1:0] byte_lane_write_n = '1, parity_lane_in, parity_lane_out;
    logic [`LANES*`BYTE_W-1:0] dq_in, dq_out;
    logic dq_oe, write_buffer_ready;
    logic [`DATA_W-1:0] wdata = '0;
    int error_cnt = 0, n_compared = 0;
    sram_pin_ctrl dut_u (.clk, .srst, .addr_upper, .burst_second_bit, .burst_low_bit,
        .byte_lane_write_n, .write_n, .advance_or_load, .clock_gate_n, .select_low_first,
        .select_high, .select_low_second, .output_enable_n, .burst_order_mode, .dq_in,
        .parity_lane_in, .dq_out, .parity_lane_out, .dq_oe, .write_buffer_ready);
    sram_host_model host_u (.clk, .clock_gate_n, .write_n, .wdata, .dq_in, .parity_lane_in);
    initial forever #25 clk = ~clk;
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic chk(string w, logic [`DATA_W-1:0] e, logic [`DATA_W-1:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic chk_flag(string w, logic e, logic g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", w, e, g);
        end
    endtask : chk_flag
    task automatic beat(logic g, logic a, logic [2:0] s, logic w, logic [`ADDR_W-1:0] ad,
        logic [`LANES-1:0] l, logic [`DATA_W-1:0] d);
        @(posedge clk);
        clock_gate_n <= g;
        advance_or_load <= a;
        {select_low_first, select_high, select_low_second} <= s;
        write_n <= w;
        {addr_upper, burst_second_bit, burst_low_bit} <= ad;
        byte_lane_write_n <= l;
        wdata <= d;
    endtask : beat
    task automatic idle(int n);
        repeat (n) beat(1'b0, 1'b0, 3'h0, 1'b1, '0, 4'hF, '0);
    endtask : idle
    task automatic rd(logic [`ADDR_W-1:0] ad, logic [`DATA_W-1:0] e);
        beat(1'b0, 1'b0, 3'h2, 1'b1, ad, 4'hF, '0);
        idle(2);
        @(posedge clk);
        #1;
        chk("read data", e, {parity_lane_out, dq_out});
        chk_flag("drive", !output_enable_n, dq_oe);
    endtask : rd
    task automatic burst(logic m, logic [`ADDR_W-1:0] base);
        @(posedge clk);
        srst <= 1'b1;
        burst_order_mode <= m;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset data", '0, {parity_lane_out, dq_out});
        beat(1'b0, 1'b0, 3'h2, 1'b0, base | 19'h1, 4'h0, 36'h1);
        for (int n = 1; n < 4; n++) beat(1'b0, 1'b1, 3'h2, 1'b0, base, 4'h0, 36'(n + 1));
        idle(4);
        for (int k = 0; k < 4; k++) rd(base | 19'(k), 36'((m ? (k ^ 1) : ((k + 3) % 4)) + 1));
    endtask : burst
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk_flag("ready", 1'b1, write_buffer_ready);
        chk_flag("reset drive", 1'b0, dq_oe);
        for (int i = 0; i < 6; i++) begin
            beat(1'b0, 1'b0, 3'h2, 1'b0, rows[i].ad, 4'h0, '0);
            beat(1'b0, 1'b0, 3'h2, 1'b0, rows[i].ad, rows[i].l, '1);
            idle(4);
            rd(rows[i].ad, rows[i].exp);
        end
        beat(1'b0, 1'b0, 3'h2, 1'b1, '0, 4'hF, '0);
        repeat (3) beat(1'b1, 1'b0, 3'h2, 1'b0, '0, 4'h0, '0);
        idle(2);
        @(posedge clk);
        #1;
        chk("gated read", '1, {parity_lane_out, dq_out});
        chk_flag("gated drive", 1'b1, dq_oe);
        for (int s = 0; s < 8; s++) begin
            if (s != 2) beat(1'b0, 1'b0, 3'(s), 1'b0, '0, 4'h0, '0);
        end
        idle(4);
        rd('0, '1);
        @(posedge clk);
        output_enable_n <= 1'b1;
        rd(19'h12345, 36'h5_00FF_00FF);
        // The burst's first data beat comes out at the edge where the enable drops, so both move the drive together.
        beat(1'b0, 1'b0, 3'h2, 1'b1, 19'h00003, 4'hF, '0);
        repeat (2) beat(1'b0, 1'b1, 3'h2, 1'b1, 19'h00003, 4'hF, '0);
        @(posedge clk);
        output_enable_n <= 1'b0;
        #1;
        chk_flag("async drive", 1'b1, dq_oe);
        chk("async data", 36'hA_FF00_FF00, {parity_lane_out, dq_out});
        burst(1'b1, 19'h00100);
        burst(1'b0, 19'h00200);
        summarize();
    end
endmodule : pipelined_sram_pin_control_bench
